// >>> hw/eris_i2c_slave.sv
// Purpose: two-wire slave port with write FIFO and nonvolatile commit
// Assumes: serial clock far slower than sys_clk, open-drain data pin
// Notes  : memory contents live outside; read data is looked up live
`timescale 1ns/1ps

module eris_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,       // System clock
   input  wire logic         rst_n,     // Synchronised reset
   input  wire logic         in_valid,  // Write side valid
   output logic              in_ready,  // Not full
   input  wire logic [W-1:0] in_data,   // Write side data
   output logic              out_valid, // Not empty
   input  wire logic         out_ready, // Drain side ready
   output logic [W-1:0]      out_data   // Head entry
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
      logic                    ne;
      logic [W-1:0]            head;
   } eris_fifo_s_t;
   eris_fifo_s_t r, next_r;

   // Pointers carry a wrap bit so full and empty stay distinct
   assign in_ready  = (r.wp[AW-1:0] != r.rp[AW-1:0]) || (r.wp[AW] == r.rp[AW]);
   assign out_valid = r.ne;
   assign out_data  = r.head;

   always_comb begin
      next_r = r;
      if (in_valid && in_ready) begin
         next_r.mem[r.wp[AW-1:0]] = in_data;
         next_r.wp = r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_r.rp = r.rp + 1'b1;
      end
      // Drain side outputs come from flops, not from the pointer compare
      next_r.ne   = next_r.wp != next_r.rp;
      next_r.head = next_r.mem[next_r.rp[AW-1:0]];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module eris_i2c_slave #(
   parameter int NVW_CNT = eris_pkg::NVW_CYCLES
) (
   input  wire logic          sys_clk,   // 200 MHz clock
   input  wire logic          rstn,      // Async reset, active low
   input  wire logic          scl,       // Serial clock pin
   input  wire logic          sda_i,     // Serial data pin level
   output logic               sda_o,     // Data drive value, always low
   output logic               sda_oe,    // High while pulling data low
   input  wire logic          act_hold,  // Activity pin, high blocks writes
   input  wire logic          pw_ok,     // Password matched
   output logic [7:0]         rd_addr,   // Address counter
   input  wire logic [7:0]    rd_data,   // Byte at rd_addr
   output logic               wr_valid,  // Written byte waiting
   input  wire logic          wr_ready,  // Device takes the byte
   output eris_pkg::eris_wr_ent_t wr_ent, // Written address and data
   output logic               nv_commit, // Pulse: start nonvolatile write
   output logic               nv_busy    // Nonvolatile write in progress
);
   import eris_pkg::*;

   typedef struct packed {
      logic [1:0]   scl_p;
      logic [1:0]   sda_p;
      logic [1:0]   act_p;
      logic         scl_d;
      logic         sda_d;
      eris_st_t     st;
      eris_kind_t   k;
      logic [3:0]   cnt;
      logic [7:0]   sh;
      logic [7:0]   addr;
      logic         rd;
      logic         ack;
      logic         wrote;
      logic         oe;
      logic         commit;
      logic         busy;
      logic [23:0]  tmr;
      logic         push;
      eris_wr_ent_t ent;
   } eris_s_t;

   eris_s_t    r, next_r;
   // Pin history starts at the idle bus level, so no false edge after reset
   localparam eris_s_t IDLE_S = '{scl_p: 2'h3, sda_p: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                                  st: S_IDLE, k: K_SLV, default: '0};
   logic [1:0] rst_q;
   logic       rst_n_s;
   logic       fifo_rdy;
   logic       scl_h, sda, scl_rise, scl_fall, start_c, stop_c;

   function automatic logic [7:0] row_inc(input logic [7:0] a);
      row_inc = {a[7:ROW_BITS], a[ROW_BITS-1:0] + 1'b1};
   endfunction

   function automatic logic is_prot(input logic [7:0] a);
      is_prot = (a >= PROT_LO) && (a <= PROT_HI);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_q[1];

   // Stage 0 of each pin synchroniser feeds only stage 1
   assign scl_h    = r.scl_p[1];
   assign sda      = r.sda_p[1];
   assign scl_rise = scl_h && !r.scl_d;
   assign scl_fall = !scl_h && r.scl_d;
   assign start_c  = scl_h && r.scl_d && r.sda_d && !sda;
   assign stop_c   = scl_h && r.scl_d && !r.sda_d && sda;

   always_comb begin
      next_r        = r;
      next_r.scl_p  = {r.scl_p[0], scl};
      next_r.sda_p  = {r.sda_p[0], sda_i};
      next_r.act_p  = {r.act_p[0], act_hold};
      next_r.scl_d  = r.scl_p[1];
      next_r.sda_d  = r.sda_p[1];
      next_r.push   = 1'b0;
      next_r.commit = 1'b0;
      if (r.busy) begin
         if (r.tmr == 24'h0) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.tmr = r.tmr - 24'h1;
         end
      end
      if (start_c) begin
         // Repeated start drops pending bytes from the commit
         next_r.st    = S_RX;
         next_r.k     = K_SLV;
         next_r.cnt   = 4'h0;
         next_r.oe    = 1'b0;
         next_r.wrote = 1'b0;
      end else if (stop_c) begin
         next_r.st = S_IDLE;
         next_r.oe = 1'b0;
         if (r.wrote) begin
            next_r.commit = 1'b1;
            next_r.busy   = 1'b1;
            next_r.tmr    = 24'(NVW_CNT - 1);
            next_r.wrote  = 1'b0;
         end
      end else begin
         case (r.st)
            S_RX: begin
               if (scl_rise && r.cnt < BYTE_BITS) begin
                  next_r.sh  = {r.sh[6:0], sda};
                  next_r.cnt = r.cnt + 4'h1;
               end else if (scl_fall && r.cnt == BYTE_BITS) begin
                  next_r.st  = S_ACK;
                  next_r.ack = 1'b0;
                  case (r.k)
                     K_SLV: begin
                        if (r.sh[7:1] == SLAVE_ADDR && !r.busy) begin
                           next_r.ack = 1'b1;
                           next_r.rd  = r.sh[RW_BIT];
                        end
                     end
                     K_MEM: begin
                        next_r.ack  = 1'b1;
                        next_r.addr = r.sh;
                     end
                     default: begin
                        // A full FIFO is refused with a nack rather than lost
                        if (!r.act_p[1] && (!is_prot(r.addr) || pw_ok) && fifo_rdy) begin
                           next_r.ack   = 1'b1;
                           next_r.push  = 1'b1;
                           next_r.ent   = '{addr: r.addr, data: r.sh};
                           next_r.wrote = 1'b1;
                           next_r.addr  = row_inc(r.addr);
                        end
                     end
                  endcase
                  next_r.oe = next_r.ack;
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  next_r.cnt = 4'h0;
                  if (!r.ack) begin
                     next_r.st = S_IGNORE;
                     next_r.oe = 1'b0;
                  end else if (r.rd) begin
                     next_r.st = S_TX;
                     next_r.sh = {rd_data[6:0], 1'b0};
                     next_r.oe = !rd_data[7];
                  end else begin
                     next_r.st = S_RX;
                     next_r.oe = 1'b0;
                     next_r.k  = (r.k == K_SLV) ? K_MEM : K_DAT;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  next_r.cnt = r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r.cnt == BYTE_BITS) begin
                     next_r.oe = 1'b0;
                     next_r.st = S_MACK;
                  end else begin
                     next_r.oe = !r.sh[7];
                     next_r.sh = {r.sh[6:0], 1'b0};
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  next_r.addr = r.addr + 8'h1;
                  if (sda) begin
                     next_r.st = S_IGNORE;
                  end else begin
                     next_r.st  = S_ACK;
                     next_r.ack = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         r <= IDLE_S;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   eris_fifo #(.W($bits(eris_wr_ent_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n_s),
      .in_valid  (r.push),
      .in_ready  (fifo_rdy),
      .in_data   (r.ent),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_ent)
   );

   assign sda_o     = 1'b0;
   assign sda_oe    = r.oe;
   assign rd_addr   = r.addr;
   assign nv_commit = r.commit;
   assign nv_busy   = r.busy;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n_s);

   sequence s_byte_done;
      r.st == S_RX && scl_fall && r.cnt == BYTE_BITS;
   endsequence
   sequence s_master_nack;
      r.st == S_MACK && scl_rise && sda;
   endsequence

   property p_start;
      start_c |=> r.st == S_RX && r.cnt == 4'h0 && !r.oe;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      stop_c && r.wrote |=> r.st == S_IDLE && nv_commit ##1 nv_busy && !nv_commit;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not commit");

   property p_sample;
      r.st == S_RX && scl_rise && r.cnt < BYTE_BITS && !start_c && !stop_c |=> r.sh[0] == $past(sda);
   endproperty
   a_sample: assert property (p_sample) else $error("bit not sampled on rise");

   property p_drive_edge;
      $changed(r.oe) |-> $past(scl_fall || start_c || stop_c);
   endproperty
   a_drive_edge: assert property (p_drive_edge) else $error("data changed off falling edge");

   property p_nomatch;
      s_byte_done and (r.k == K_SLV && r.sh[7:1] != SLAVE_ADDR && !start_c && !stop_c)
         |=> !r.oe ##1 (r.st == S_ACK || r.st == S_IGNORE);
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("foreign address acknowledged");

   property p_busy_nack;
      s_byte_done and (r.k == K_SLV && r.busy && !start_c && !stop_c) |=> !r.oe;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

   property p_wrap;
      r.push |-> r.addr[7:ROW_BITS] == r.ent.addr[7:ROW_BITS];
   endproperty
   a_wrap: assert property (p_wrap) else $error("write counter left row");

   property p_release;
      s_master_nack and (!start_c && !stop_c) |=> r.st == S_IGNORE && !r.oe [*2];
   endproperty
   a_release: assert property (p_release) else $error("data held after nack");

   property p_inhibit;
      r.push |-> !$past(r.act_p[1]);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("write taken while held");
endmodule

// >>> hw/eris_pkg.sv
// Purpose: constants and types of the recorder's two-wire slave port
// Assumes: 200 MHz system clock, bus master drives the serial clock
// Notes  : one line per rule of the port follows
// Overview of operation
// - data falling while clock high starts transfer
// - data rising while clock high ends transfer
// - data stable while clock high; sample rising
// - transmit bits change after falling clock edge
// - ninth bit is acknowledge; low means ack
// - eight bits, msb first, then acknowledge
// - master nack on last read; release data
// - first byte: 7-bit address plus direction
// - answer only address bytes D6h and D7h
// - mismatch: nack, ignore until next start
// - byte after write address loads counter
// - stop commits nonvolatile; repeated start does not
// - one to eight bytes, consecutive addresses
// - write counter wraps inside 8-byte row
// - no address ack during nonvolatile write
// - bare read starts at current counter
// - random read: address write, repeated start, read
// - master ack requests next byte; nack ends
// - repeated start accepted mid transfer
// - activity input high rejects written data
// - protected writes need password; reads allowed
package eris_pkg;
   localparam logic [6:0]  SLAVE_ADDR  = 7'h6B;
   localparam int          RW_BIT      = 0;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam int          ROW_BITS    = 3;
   localparam logic [7:0]  PROT_LO     = 8'h20;
   localparam logic [7:0]  PROT_HI     = 8'h2F;
   localparam int          CLK_MHZ     = 200;
   localparam int          NVW_TIME_US = 10;
   localparam int          NVW_CYCLES  = NVW_TIME_US * CLK_MHZ;
   localparam int          FIFO_DEPTH  = 8;

   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_IGNORE} eris_st_t;
   typedef enum logic [1:0] {K_SLV, K_MEM, K_DAT} eris_kind_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } eris_wr_ent_t;
endpackage

// >>> test/eris_i2c_master.sv
// Purpose: behavioural two-wire bus master facing the slave port
// Assumes: data wire pulled up, 125 ns serial clock period
// Notes  : serial clock stands high between frames
`timescale 1ns/1ps

module eris_i2c_master (
   output logic      scl,   // Serial clock, push-pull
   output logic      sda_m, // Data drive, 1 = released
   input  wire logic sda    // Wired data level
);
   localparam real Q = 31.25;

   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Also serves as repeated start
   task automatic start();
      if (scl == 1'b0) begin
         #Q sda_m = 1'b1;
         #Q scl = 1'b1;
         #Q;
      end
      sda_m = 1'b0;
      #(2*Q) scl = 1'b0;
   endtask

   task automatic stop();
      #Q sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #(2*Q);
   endtask

   // Data moves a quarter period after the fall, never near an edge
   task automatic bit_io(input logic b, output logic r);
      #Q sda_m = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule

// >>> test/test_eris_i2c_slave.sv
// Purpose: self-checking bench of the two-wire slave port
// Assumes: read data is address xor 5Ah, short commit timer
// Notes  : written bytes pile up in the FIFO and are drained later
`timescale 1ns/1ps

module test_eris_i2c_slave;
   import eris_pkg::*;
   localparam int NVW = 400;
   logic         sys_clk  = 1'b0;
   logic         rstn     = 1'b0;
   logic         act_hold = 1'b0;
   logic         pw_ok    = 1'b1;
   logic         wr_ready = 1'b0;
   logic         scl, sda_m, sda_o, sda_oe, wr_valid, nv_commit, nv_busy;
   logic [7:0]   rd_addr, rd_data;
   eris_wr_ent_t wr_ent;
   wire logic    sda_w;
   int           errors = 0;
   int           total_checks = 0;
   int           commits = 0;

   // Open drain with pull-up
   assign sda_w   = sda_m & ~sda_oe;
   assign rd_data = rd_addr ^ 8'h5A;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (nv_commit === 1'b1) commits <= commits + 1;

   eris_i2c_master u_mst (.scl(scl), .sda_m(sda_m), .sda(sda_w));

   eris_i2c_slave #(.NVW_CNT(NVW)) u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .act_hold(act_hold), .pw_ok(pw_ok), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_ent(wr_ent), .nv_commit(nv_commit), .nv_busy(nv_busy)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] d, input logic exp_ack);
      logic ack;
      u_mst.wbyte(d, ack);
      check(ack, exp_ack, "ack");
   endtask

   // Takes one entry, then stalls a cycle
   task automatic take(input logic [15:0] exp);
      @(posedge sys_clk) #1;
      for (int n = 0; n < 100 && wr_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      check(wr_ent, exp, "fifo entry");
      wr_ready = 1'b1;
      @(posedge sys_clk) #1 wr_ready = 1'b0;
      @(posedge sys_clk) #1;
   endtask

   task automatic wait_idle();
      for (int n = 0; n < 3 * NVW && nv_busy !== 1'b0; n++) @(posedge sys_clk) #1;
      check(nv_busy, 1'b0, "busy end");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_page();
      int c0;
      c0 = commits;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h06, 1'b1);
      for (int i = 0; i < 8; i++) wr(8'(8'h11 * (i + 1)), 1'b1);
      u_mst.stop();
      check(16'(commits), 16'(c0 + 1), "commit");
      u_mst.start();
      wr(8'hD6, 1'b0);
      u_mst.stop();
      wait_idle();
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h50, 1'b1);
      wr(8'hEE, 1'b0); // FIFO full refuses
      u_mst.stop();
      check(16'(commits), 16'(c0 + 1), "empty stop");
      for (int i = 0; i < 8; i++) take({8'((6 + i) % 8), 8'(8'h11 * (i + 1))});
   endtask

   task automatic t_read();
      logic [7:0] d;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h10, 1'b1);
      u_mst.start();
      wr(8'hD7, 1'b1);
      u_mst.rbyte(1'b0, d);
      check(d, 8'h10 ^ 8'h5A, "random read");
      u_mst.rbyte(1'b1, d);
      check(d, 8'h11 ^ 8'h5A, "next read");
      check(sda_oe, 1'b0, "release");
      u_mst.stop();
      check(rd_addr, 8'h12, "counter");
      u_mst.start();
      wr(8'hD7, 1'b1);
      u_mst.rbyte(1'b1, d);
      u_mst.stop();
      check(d, 8'h12 ^ 8'h5A, "current read");
   endtask

   task automatic t_bad();
      logic [7:0] bad [3] = '{8'hA0, 8'h56, 8'hD4};
      for (int i = 0; i < 3; i++) begin
         u_mst.start();
         wr(bad[i], 1'b0);
         wr(8'h00, 1'b0);
         u_mst.stop();
      end
   endtask

   task automatic t_rstart();
      logic [7:0] d;
      int c0;
      c0 = commits;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h37, 1'b1);
      wr(8'h44, 1'b1);
      u_mst.start();
      wr(8'hD7, 1'b1);
      u_mst.rbyte(1'b1, d);
      u_mst.stop();
      check(d, 8'h30 ^ 8'h5A, "wrapped counter");
      check(16'(commits), 16'(c0), "no commit");
      take(16'h3744);
   endtask

   task automatic t_guard();
      @(posedge sys_clk) #1 pw_ok = 1'b0;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h24, 1'b1);
      wr(8'h77, 1'b0);
      u_mst.stop();
      @(posedge sys_clk) #1 act_hold = 1'b1;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h40, 1'b1);
      wr(8'h88, 1'b0);
      u_mst.stop();
      check(wr_valid, 1'b0, "nothing queued");
      @(posedge sys_clk) #1 act_hold = 1'b0;
      pw_ok = 1'b1;
      u_mst.start();
      wr(8'hD6, 1'b1);
      wr(8'h25, 1'b1);
      wr(8'h99, 1'b1);
      u_mst.stop();
      wait_idle();
      take(16'h2599);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      errors++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      #1 rstn = 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
      check({sda_oe, sda_o, wr_valid, nv_busy, rd_addr}, 16'h0000, "reset values");
      t_page();
      t_read();
      t_bad();
      t_rstart();
      t_guard();
      close_out();
   end
endmodule
